// [led_grayscale_pwm_engine_tb_top.sv]
// Self-checking bench of the grayscale PWM engine with its controller model.
`include "lgpe_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module led_grayscale_pwm_engine_tb_top import lgpe_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a; logic w; logic [31:0] d; logic [1:0] wr; logic [31:0] q; logic [1:0] rr;
  } lgpe_row_s;
  localparam lgpe_row_s ROWS [10] = '{
    '{`LGPE_ADDR_CTRL, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0}, '{`LGPE_ADDR_BRIGHT, 1'b0, 32'h0, 2'h0, 32'hffff, 2'h0},
    '{`LGPE_ADDR_STEP, 1'b0, 32'h0, 2'h0, 32'h1000, 2'h0}, '{`LGPE_ADDR_STAT, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0},
    '{`LGPE_ADDR_MASK, 1'b0, 32'h0, 2'h0, 32'h0, 2'h0}, '{`LGPE_ADDR_BRIGHT, 1'b1, 32'h12345678, 2'h0, 32'h5678, 2'h0},
    '{8'h80, 1'b1, 32'hffffffff, 2'h0, 32'h7f, 2'h0}, '{8'h44, 1'b1, 32'h00000abc, 2'h0, 32'habc, 2'h0},
    '{8'h3c, 1'b1, 32'h1, 2'h2, 32'h0, 2'h2}, '{`LGPE_ADDR_CTRL, 1'b1, 32'hffffffc5, 2'h0, 32'h5, 2'h0}};
  logic          aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]   wdata = 32'h0, rd, last_late = 32'h0;
  logic [3:0]    wstrb = 4'hf;
  logic [15:0]   open_f = 16'h0, short_f = 16'h0;
  logic [11:0]   gs_tab [16];
  logic [1:0]    rs;
  wire logic     awready, wready, bvalid, arready, rvalid, irq, step_clk, blank_n, gs_strobe;
  wire logic [1:0]   bresp, rresp, trim_range;
  wire logic [31:0]  rdata;
  wire logic [7:0]   sink_a, sink_b;
  wire logic [15:0]  bright;
  wire logic [111:0] trim;
  wire logic [36:0]  rst_view = {awready, bvalid, sink_b, sink_a, bright, trim_range, irq};
  localparam logic [36:0] RST_VIEW = {1'b1, 1'b0, 16'h0, 16'hffff, 2'h0, 1'b0};
  int            num_errors = 0, checked = 0;
  always #20 aclk = ~aclk;
  lgpe_core u_lgpe_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_step_clock(step_clk),
    .blank_n(blank_n), .gs_load_strobe(gs_strobe), .open_led_flag(open_f), .shorted_led_flag(short_f),
    .sink_group_a(sink_a), .sink_group_b(sink_b), .group_brightness_code(bright), .trim_range(trim_range),
    .channel_trim_code(trim), .irq(irq));
  lgpe_host_model u_lgpe_host_model (.pwm_step_clock(step_clk), .blank_n(blank_n), .gs_load_strobe(gs_strobe));
  task automatic finish_test();
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    r = bresp;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd_reg
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
  endtask : w
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd, rs);
    `CHK("read data", e, rd)
  endtask : chk_rd
  function automatic logic [15:0] exp_sink(input int c);
    logic [15:0] v;
    for (int i = 0; i < 16; i++) v[i] = (gs_tab[i] != 12'h000) && (c < int'(gs_tab[i]));
    return v;
  endfunction : exp_sink
  // One full cycle without repeat: early and late capture, then the engine parks.
  task automatic run_cycle(input logic [1:0] md, input int mx, input logic [31:0] fa, input logic [31:0] fb);
    w(`LGPE_ADDR_STAT, 32'h7);
    w(`LGPE_ADDR_CTRL, 32'(md));
    open_f <= fa[15:0];
    short_f <= fa[31:16];
    u_lgpe_host_model.blank_set(1'b0);
    u_lgpe_host_model.blank_set(1'b1);
    u_lgpe_host_model.steps(9);
    chk_rd(`LGPE_ADDR_EARLY, fa);
    @(posedge aclk);
    open_f <= fb[15:0];
    short_f <= fb[31:16];
    u_lgpe_host_model.steps(mx - 11);
    chk_rd(`LGPE_ADDR_STEP, {17'h0, 3'b010, 12'(mx - 2)});
    u_lgpe_host_model.steps(1);
    chk_rd(`LGPE_ADDR_LATE, last_late);
    u_lgpe_host_model.steps(1);
    chk_rd(`LGPE_ADDR_LATE, fb);
    last_late = fb;
    u_lgpe_host_model.steps(2);
    rd_reg(`LGPE_ADDR_STEP, rd, rs);
    `CHK("cycle state", 3'b100, rd[14:12])
    `CHK("sinks after cycle", 16'h0, {sink_b, sink_a})
    chk_rd(`LGPE_ADDR_STAT, 32'h7);
  endtask : run_cycle
  initial begin
    #(80000 * 40);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    `CHK("reset outputs", RST_VIEW, rst_view)
    `CHK("reset trim", 112'h0, trim)
    aresetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) begin
        wr(ROWS[i].a, ROWS[i].d, rs);
        `CHK("write response", ROWS[i].wr, rs)
      end
      rd_reg(ROWS[i].a, rd, rs);
      `CHK("read data", ROWS[i].q, rd)
      `CHK("read response", ROWS[i].rr, rs)
    end
    w(`LGPE_ADDR_BRIGHT, 32'h0000a55a);
    w(`LGPE_ADDR_CTRL, 32'h00000030);
    for (int i = 0; i < 16; i++) w(8'h80 + 8'(4 * i), 32'(i + 8'h60));
    repeat (2) @(posedge aclk);
    `CHK("group brightness", 16'ha55a, bright)
    `CHK("trim range", 2'h3, trim_range)
    for (int i = 0; i < 16; i++) `CHK("trim code", 7'(i + 8'h60), trim[7*i +: 7])
    w(`LGPE_ADDR_CMD, 32'h1);
    chk_rd(`LGPE_ADDR_SNAP, 32'h0030a55a);
    wstrb <= 4'h2;
    w(`LGPE_ADDR_BRIGHT, 32'h000012ff);
    wstrb <= 4'hf;
    chk_rd(`LGPE_ADDR_BRIGHT, 32'h0000125a);
    gs_tab = '{default: 12'h000};
    gs_tab[1] = 12'h001;
    gs_tab[2] = 12'h009;
    gs_tab[8] = 12'h0c8;
    gs_tab[9] = 12'h003;
    for (int i = 0; i < 16; i++) w(8'h40 + 8'(4 * i), 32'(gs_tab[i]));
    w(`LGPE_ADDR_CTRL, 32'h0);
    u_lgpe_host_model.load();
    run_cycle(2'h2, 255, 32'h0f0000f0, 32'h43211234);
    `CHK("masked irq", 1'b0, irq)
    w(`LGPE_ADDR_MASK, 32'h4);
    repeat (2) @(posedge aclk);
    `CHK("irq raised", 1'b1, irq)
    w(`LGPE_ADDR_STAT, 32'h4);
    chk_rd(`LGPE_ADDR_STAT, 32'h3);
    `CHK("irq cleared", 1'b0, irq)
    w(`LGPE_ADDR_MASK, 32'h0);
    run_cycle(2'h1, 1023, 32'h00ff0a0a, 32'h5555aaaa);
    run_cycle(2'h0, 4095, 32'hc0030c30, 32'h8001f00f);
    w(`LGPE_ADDR_CTRL, 32'h2);
    u_lgpe_host_model.blank_set(1'b0);
    rd_reg(`LGPE_ADDR_STEP, rd, rs);
    `CHK("blanked count", 12'h000, rd[11:0])
    `CHK("blanked sinks", 16'h0, {sink_b, sink_a})
    u_lgpe_host_model.blank_set(1'b1);
    chk_rd(`LGPE_ADDR_STEP, 32'h00002000);
    `CHK("cycle start sinks", exp_sink(0), {sink_b, sink_a})
    u_lgpe_host_model.steps(5);
    chk_rd(`LGPE_ADDR_STEP, 32'h00002005);
    `CHK("sinks at step 5", exp_sink(5), {sink_b, sink_a})
    w(`LGPE_ADDR_CTRL, 32'h6);
    u_lgpe_host_model.steps(253);
    chk_rd(`LGPE_ADDR_STEP, 32'h00002002);
    `CHK("repeat sinks", exp_sink(2), {sink_b, sink_a})
    w(`LGPE_ADDR_CTRL, 32'h2);
    w(8'h4c, 32'h32);
    u_lgpe_host_model.load();
    chk_rd(`LGPE_ADDR_STEP, 32'h00002002);
    `CHK("deferred duty", 1'b0, sink_a[3])
    gs_tab[3] = 12'h032;
    w(`LGPE_ADDR_CTRL, 32'ha);
    u_lgpe_host_model.load();
    chk_rd(`LGPE_ADDR_STEP, 32'h00002000);
    `CHK("restart sinks", exp_sink(0), {sink_b, sink_a})
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("mid reset outputs", RST_VIEW, rst_view)
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_rd(`LGPE_ADDR_STEP, 32'h00002000);
    finish_test();
  end
endmodule : led_grayscale_pwm_engine_tb_top

// [lgpe_core.sv]
// Grayscale PWM engine with AXI4-Lite registers, fault flag capture and interrupt.
// Operation
// - Global mode picks 12, 10 or 8 bit step counter range.
// - Step counter advances only on pwm_step_clock rising edges.
// - A channel turns off when the counter equals its grayscale value.
// - Blanking low clears counter; blanking high starts a fresh cycle.
// - With repeat set and blanking high, cycles restart automatically at max.
// - With timing reset, a grayscale load strobe blanks internally.
// - With repeat, internal blank occurs every full counter period.
// - Config read command copies config frame into readback register.
// - Sixteen channels in two groups of eight, each with 7-bit trim.
// - Each group holds one 8-bit brightness code.
// - Each group has selectable low or high trim range.
// - Late flags captured at step 4095 in 12-bit mode.
// - Early flags captured at step 9 of every cycle.
// - Late capture step is the mode maximum in every mode.
// - Repeat cleared: one cycle, then wait for blanking toggle.
// - Timing reset restarts at once with new values; else next cycle.
`include "lgpe_params.svh"
module lgpe_core import lgpe_pkg::*; #(
  parameter int CH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             pwm_step_clock,
  input  wire logic             blank_n,
  input  wire logic             gs_load_strobe,
  input  wire logic [CH-1:0]    open_led_flag,
  input  wire logic [CH-1:0]    shorted_led_flag,
  output logic [CH/2-1:0]       sink_group_a,
  output logic [CH/2-1:0]       sink_group_b,
  output logic [15:0]           group_brightness_code,
  output logic [1:0]            trim_range,
  output logic [CH*7-1:0]       channel_trim_code,
  output logic                  irq
);
  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  // Every non-AXI input pin, the step clock included, passes two flops before any logic reads it.
  logic [2*CH+2:0] pins_s;
  logic            step_d_reg;
  logic            load_d_reg;
  lgpe_sync #(.W(2*CH+3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({shorted_led_flag, open_led_flag, gs_load_strobe, blank_n, pwm_step_clock}),
    .q       (pins_s)
  );
  wire             step_s    = pins_s[0];
  wire             blank_s   = pins_s[1];
  wire             load_s    = pins_s[2];
  wire [2*CH-1:0]  fault_s   = pins_s[2*CH+2:3];
  wire             step_rise = step_s & ~step_d_reg;
  wire             load_rise = load_s & ~load_d_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]   ctrl_reg;
  logic [15:0]  bright_reg;
  logic [2:0]   stat_reg;
  logic [2:0]   mask_reg;
  logic [31:0]  snap_reg;
  logic [31:0]  early_reg;
  logic [31:0]  late_reg;
  logic [11:0]  gs_sh_reg  [CH];
  logic [11:0]  gs_lat_reg [CH];
  logic [11:0]  gs_act_reg [CH];
  logic [6:0]   trim_reg   [CH];
  logic [11:0]  cnt_reg;
  lgpe_state_e  st_reg;
  logic [CH-1:0] out_reg;
  logic [7:0]   awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;
  logic         irq_reg;

  function automatic logic [31:0] lgpe_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : lgpe_merge

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire        do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [1:0]  wa_reg  = awaddr_reg[7:6];
  wire [3:0]  wa_idx  = awaddr_reg[5:2];
  wire        wr_ctrl = do_wr && awaddr_reg == `LGPE_ADDR_CTRL;
  wire        wr_cmd  = do_wr && awaddr_reg == `LGPE_ADDR_CMD;
  wire        wr_stat = do_wr && awaddr_reg == `LGPE_ADDR_STAT;
  wire        wr_mask = do_wr && awaddr_reg == `LGPE_ADDR_MASK;
  wire        wr_brt  = do_wr && awaddr_reg == `LGPE_ADDR_BRIGHT;
  wire        wr_gs   = do_wr && wa_reg == `LGPE_GS_REGION;
  wire        wr_trim = do_wr && wa_reg == `LGPE_TRIM_REGION;
  wire        wr_ok   = wr_ctrl || wr_cmd || wr_stat || wr_mask || wr_brt || wr_gs || wr_trim;
  wire [31:0] wmerged = lgpe_merge(32'h0000_0000, wdata_reg, wstrb_reg);

  wire [3:0]  ra_idx  = s_axi_araddr[5:2];
  wire        ra_gs   = s_axi_araddr[7:6] == `LGPE_GS_REGION;
  wire        ra_trim = s_axi_araddr[7:6] == `LGPE_TRIM_REGION;
  wire [31:0] step_word = {17'h0_0000, st_reg, cnt_reg};
  wire        rd_ok   = ra_gs || ra_trim || s_axi_araddr <= `LGPE_ADDR_LATE && s_axi_araddr[1:0] == 2'h0;
  wire [31:0] rd_data =
    ra_gs                                  ? {20'h0_0000, gs_sh_reg[ra_idx]} :
    ra_trim                                ? {25'h000_0000, trim_reg[ra_idx]} :
    s_axi_araddr == `LGPE_ADDR_CTRL        ? {26'h000_0000, ctrl_reg} :
    s_axi_araddr == `LGPE_ADDR_SNAP        ? snap_reg :
    s_axi_araddr == `LGPE_ADDR_STAT        ? {29'h0000_0000, stat_reg} :
    s_axi_araddr == `LGPE_ADDR_MASK        ? {29'h0000_0000, mask_reg} :
    s_axi_araddr == `LGPE_ADDR_STEP        ? step_word :
    s_axi_araddr == `LGPE_ADDR_BRIGHT      ? {16'h0000, bright_reg} :
    s_axi_araddr == `LGPE_ADDR_EARLY       ? early_reg :
    s_axi_araddr == `LGPE_ADDR_LATE        ? late_reg : 32'h0000_0000;

  // A write is answered only once both address and data are in, and each ready stays low until
  // the response is taken, so at most one write and one read are under way.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LGPE_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LGPE_RESP_OKAY;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `LGPE_RESP_OKAY : `LGPE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `LGPE_RESP_OKAY : `LGPE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM step counter and cycle control
  // ----------------------------------------------------------------
  wire        auto_rep  = ctrl_reg[`LGPE_CTRL_AUTO];
  wire        tim_res   = ctrl_reg[`LGPE_CTRL_TRES];
  wire [11:0] max_cnt   = ctrl_reg[1:0] == LGPE_MODE_10 ? `LGPE_MAX_10 :
                          ctrl_reg[1:0] == LGPE_MODE_8  ? `LGPE_MAX_8 : `LGPE_MAX_12;
  // A cycle starts at count zero, so the n-th step edge brings the counter to n: the early set is
  // taken on the edge to step nine and the late set on the edge that reaches the mode maximum.
  wire [11:0] late_pt   = max_cnt - 12'h001;
  wire        in_run    = st_reg == LGPE_ST_RUN;
  wire        step_run  = in_run && step_rise;
  wire        at_max    = cnt_reg == max_cnt;
  wire        restart_tr = load_rise && tim_res && blank_s;
  wire        wrap      = step_run && at_max && auto_rep;
  wire        finish    = step_run && at_max && !auto_rep;
  wire        cyc_start = blank_s && ((st_reg == LGPE_ST_IDLE) || wrap || restart_tr);
  wire        early_cap = step_run && cnt_reg == `LGPE_EARLY_STEP - 12'h001;
  wire        late_cap  = step_run && cnt_reg == late_pt;
  wire [2:0]  events    = {late_cap, early_cap, step_run && at_max};

  lgpe_state_e st_next;
  logic [11:0] cnt_next;
  assign st_next  = !blank_s ? LGPE_ST_IDLE :
                    cyc_start ? LGPE_ST_RUN :
                    finish ? LGPE_ST_DONE : st_reg;
  assign cnt_next = (!blank_s || cyc_start) ? 12'h000 :
                    (step_run && !at_max) ? cnt_reg + 12'h001 : cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
      st_reg     <= LGPE_ST_IDLE;
      cnt_reg    <= 12'h000;
      early_reg  <= 32'h0000_0000;
      late_reg   <= 32'h0000_0000;
    end else begin
      step_d_reg <= step_s;
      load_d_reg <= load_s;
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      if (early_cap)
        early_reg <= fault_s;
      if (late_cap)
        late_reg  <= fault_s;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel grayscale, trim and output
  // ----------------------------------------------------------------
  // Grayscale moves from shadow to latch on the load strobe, and from latch to the active copy at
  // a cycle start; under timing reset the restart takes the shadow directly.
  genvar gi;
  generate
    for (gi = 0; gi < CH; gi++) begin : g_ch
      wire [11:0] act_next = !cyc_start ? gs_act_reg[gi] :
                             restart_tr ? gs_sh_reg[gi] : gs_lat_reg[gi];
      wire [11:0] act_eff  = act_next & max_cnt;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          gs_sh_reg[gi]  <= 12'h000;
          gs_lat_reg[gi] <= 12'h000;
          gs_act_reg[gi] <= 12'h000;
          trim_reg[gi]   <= 7'h00;
          out_reg[gi]    <= 1'b0;
        end else begin
          if (wr_gs && wa_idx == gi)
            gs_sh_reg[gi] <= wmerged[11:0];
          if (wr_trim && wa_idx == gi)
            trim_reg[gi] <= wmerged[6:0];
          if (load_rise)
            gs_lat_reg[gi] <= gs_sh_reg[gi];
          gs_act_reg[gi] <= act_next;
          out_reg[gi]    <= st_next == LGPE_ST_RUN && cnt_next < act_eff;
        end
      end
      assign channel_trim_code[gi*7 +: 7] = trim_reg[gi];
    end
  endgenerate

  assign sink_group_a          = out_reg[CH/2-1:0];
  assign sink_group_b          = out_reg[CH-1:CH/2];
  assign group_brightness_code = bright_reg;
  assign trim_range            = {ctrl_reg[`LGPE_CTRL_RANGE_B], ctrl_reg[`LGPE_CTRL_RANGE_A]};
  assign irq                   = irq_reg;

  // ----------------------------------------------------------------
  // Configuration, readback and interrupt
  // ----------------------------------------------------------------
  // An event in the same cycle as a software clear wins, so no event is lost.
  wire [2:0] stat_next = (stat_reg & ~(wr_stat ? wmerged[2:0] : 3'h0)) | events;
  // Control and brightness keep the bytes whose strobe is low.
  wire [31:0] ctrl_merged   = lgpe_merge({26'h000_0000, ctrl_reg}, wdata_reg, wstrb_reg);
  wire [31:0] bright_merged = lgpe_merge({16'h0000, bright_reg}, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= `LGPE_CTRL_RST;
      bright_reg <= `LGPE_BRIGHT_RST;
      mask_reg   <= 3'h0;
      stat_reg   <= 3'h0;
      snap_reg   <= 32'h0000_0000;
      irq_reg    <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_merged[5:0];
      if (wr_brt)
        bright_reg <= bright_merged[15:0];
      if (wr_mask)
        mask_reg <= wmerged[2:0];
      if (wr_cmd && wmerged[0])
        snap_reg <= {10'h000, ctrl_reg, bright_reg};
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // After a mode change the counter may stand above the new maximum until the next cycle start.
  cnt_range_a: assert property (in_run && $stable(ctrl_reg[1:0]) && $past(cnt_reg <= max_cnt) |-> cnt_reg <= max_cnt)
    else $error("step counter above mode maximum");
  cnt_step_a: assert property (blank_s && !restart_tr && !step_rise |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without a step edge");
  chan_off_a: assert property (in_run && cnt_reg >= (gs_act_reg[8] & max_cnt) |-> !out_reg[8])
    else $error("channel 8 on past its grayscale value");
  blank_clr_a: assert property (!blank_s |=> cnt_reg == 12'h000 && st_reg == LGPE_ST_IDLE && out_reg == '0)
    else $error("blanking did not clear counter");
  auto_wrap_a: assert property (step_run && at_max && auto_rep && blank_s |=> cnt_reg == 12'h000 && in_run)
    else $error("auto repeat did not restart");
  single_a: assert property ((finish || st_reg == LGPE_ST_DONE) && blank_s && !restart_tr |=>
                             st_reg == LGPE_ST_DONE && out_reg == '0)
    else $error("cycle did not stop without repeat");
  tres_a: assert property (restart_tr |=> cnt_reg == 12'h000 && gs_act_reg[1] == $past(gs_sh_reg[1]))
    else $error("timing reset did not restart with new values");
  early_a: assert property (early_cap |=> early_reg == $past(fault_s) ##1 cnt_reg >= `LGPE_EARLY_STEP || !in_run)
    else $error("early flags not captured at step nine");
  late_a: assert property (late_cap |=> late_reg == $past(fault_s) && cnt_reg == max_cnt)
    else $error("late flags not captured on the edge to the mode maximum");
  snap_a: assert property (wr_cmd && wmerged[0] |=> snap_reg[21:0] == $past({ctrl_reg, bright_reg}))
    else $error("config readback not copied");
  zero_off_a: assert property (gs_act_reg[2] == 12'h000 |-> !out_reg[2])
    else $error("zero grayscale channel turned on");

  stat_set_a: assert property (events[2] |=> stat_reg[2])
    else $error("late capture event lost");
  irq_lvl_a: assert property (|(stat_reg & mask_reg) && $stable(mask_reg) |-> irq_reg)
    else $error("interrupt low while an unmasked status bit is set");

  wrap_c:  cover property (wrap);
  tres_c:  cover property (restart_tr);
  late_c:  cover property (late_cap);
  irq_c:   cover property (irq_reg);
  early_c: cover property (early_cap);
endmodule : lgpe_core

// [lgpe_host_model.sv]
// Model of the external controller that drives the step clock, blanking and load strobe.
module lgpe_host_model (
  output logic pwm_step_clock,
  output logic blank_n,
  output logic gs_load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pwm_step_clock = 1'b0;
    blank_n        = 1'b0;
    gs_load_strobe = 1'b0;
  end
  // The step clock rests low between frames and starts off the bus clock phase.
  task automatic steps(input int n);
    #13;
    repeat (n) begin
      pwm_step_clock = 1'b1;
      #160;
      pwm_step_clock = 1'b0;
      #160;
    end
  endtask : steps
  // Blanking is toggled after a finished cycle, or held high while the engine blanks itself.
  task automatic blank_set(input logic lvl);
    #13;
    blank_n = lvl;
    #200;
  endtask : blank_set
  task automatic load();
    #13;
    gs_load_strobe = 1'b1;
    #200;
    gs_load_strobe = 1'b0;
    #200;
  endtask : load
endmodule : lgpe_host_model

// [lgpe_params.svh]
// Register offsets, field positions, reset values and step counts of the grayscale PWM engine.
`ifndef LGPE_PARAMS_SVH
`define LGPE_PARAMS_SVH
`define LGPE_ADDR_CTRL      8'h00
`define LGPE_ADDR_CMD       8'h04
`define LGPE_ADDR_SNAP      8'h08
`define LGPE_ADDR_STAT      8'h0c
`define LGPE_ADDR_MASK      8'h10
`define LGPE_ADDR_STEP      8'h14
`define LGPE_ADDR_BRIGHT    8'h18
`define LGPE_ADDR_EARLY     8'h1c
`define LGPE_ADDR_LATE      8'h20
`define LGPE_GS_REGION      2'h1
`define LGPE_TRIM_REGION    2'h2
`define LGPE_CTRL_AUTO      2
`define LGPE_CTRL_TRES      3
`define LGPE_CTRL_RANGE_A   4
`define LGPE_CTRL_RANGE_B   5
`define LGPE_CTRL_RST       6'h00
`define LGPE_BRIGHT_RST     16'hffff
`define LGPE_MAX_12         12'hfff
`define LGPE_MAX_10         12'h3ff
`define LGPE_MAX_8          12'h0ff
`define LGPE_EARLY_STEP     12'h009
`define LGPE_RESP_OKAY      2'h0
`define LGPE_RESP_SLVERR    2'h2
`endif

// [lgpe_pkg.sv]
// Types shared by the grayscale PWM engine.
package lgpe_pkg;
  typedef enum logic [2:0] {
    LGPE_ST_IDLE = 3'b001,
    LGPE_ST_RUN  = 3'b010,
    LGPE_ST_DONE = 3'b100
  } lgpe_state_e;
  typedef enum logic [1:0] {
    LGPE_MODE_12 = 2'h0,
    LGPE_MODE_10 = 2'h1,
    LGPE_MODE_8  = 2'h2
  } lgpe_mode_e;
endpackage : lgpe_pkg

// [lgpe_sync.sv]
// Two-flop synchroniser for pins from outside the aclk domain.
module lgpe_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : lgpe_sync
